// File: ccd_pkg.sv
// Purpose: constants and carrier types of the codec clock/datapath register bank
// Assumes: 8-bit registers on page 0, reached through a decoded control-bus port
// Notes:   field positions count from d0 = bit 0
package ccd_pkg;

    // ------------------------------------------------------------------
    // register offsets and reset values
    // ------------------------------------------------------------------
    localparam int             CCD_ADDR_W      = 7;
    localparam logic [6:0]     CCD_OFS_PLL_A   = 7'h03;
    localparam logic [6:0]     CCD_OFS_PLL_J   = 7'h04;
    localparam logic [6:0]     CCD_OFS_FRAC_HI = 7'h05;
    localparam logic [6:0]     CCD_OFS_FRAC_LO = 7'h06;
    localparam logic [6:0]     CCD_OFS_DPATH   = 7'h07;
    localparam logic [6:0]     CCD_OFS_SPORT   = 7'h08;
    localparam logic [7:0]     CCD_RST_PLL_A   = 8'h10;
    localparam logic [7:0]     CCD_RST_PLL_J   = 8'h04;
    localparam logic [7:0]     CCD_RST_FRAC_HI = 8'h00;
    localparam logic [7:0]     CCD_RST_FRAC_LO = 8'h00;
    localparam logic [7:0]     CCD_RST_DPATH   = 8'h00;
    localparam logic [7:0]     CCD_RST_SPORT   = 8'h00;
    localparam logic [7:0]     CCD_RD_UNMAPPED = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CCD_PLL_EN_BIT  = 7;
    localparam int CCD_Q_MSB       = 6;
    localparam int CCD_Q_LSB       = 3;
    localparam int CCD_P_MSB       = 2;
    localparam int CCD_J_MSB       = 7;
    localparam int CCD_J_LSB       = 2;
    localparam int CCD_FRAC_LO_LSB = 2;
    localparam int CCD_FSREF_BIT   = 7;
    localparam int CCD_ADC_DR_BIT  = 6;
    localparam int CCD_DAC_DR_BIT  = 5;
    localparam int CCD_LSRC_LSB    = 3;
    localparam int CCD_RSRC_LSB    = 1;
    localparam int CCD_BCLK_M_BIT  = 7;
    localparam int CCD_WCLK_M_BIT  = 6;
    localparam int CCD_DOUT_TS_BIT = 5;
    localparam int CCD_CLK_KEEP_BIT = 4;
    localparam int CCD_FX3D_BIT    = 2;
    localparam int CCD_FRAC_W      = 14;
    localparam int CCD_FRAC_MAX    = 9999;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {CCD_SRC_MUTE, CCD_SRC_LEFT, CCD_SRC_RIGHT, CCD_SRC_MONO} ccd_dac_src_t;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [CCD_ADDR_W-1:0] addr;
        logic [7:0]            wdata;
    } ccd_req_t;

    typedef struct packed {
        logic                  pll_en;
        logic [4:0]            pll_q;
        logic [3:0]            pll_p;
        logic [5:0]            pll_j;
        logic [CCD_FRAC_W-1:0] pll_d;
        logic                  fsref_441;
        logic                  adc_dual;
        logic                  dac_dual;
        ccd_dac_src_t          left_src;
        ccd_dac_src_t          right_src;
        logic                  bclk_master;
        logic                  wclk_master;
        logic                  dout_tristate;
        logic                  clk_keep;
        logic                  effect3d;
    } ccd_cfg_t;

endpackage : ccd_pkg

// File: ccd_regs.sv
// Purpose: page-0 clock multiplier, datapath and serial-port configuration registers
// Assumes: the control-bus slave hands over decoded one-cycle read/write requests
// Notes:   decoded settings leave from flip-flops one cycle after the register updates
`timescale 1ns/1ns

module ccd_regs
    import ccd_pkg::*;
#(
    parameter int FRAC_MAX = CCD_FRAC_MAX
) (
    input  wire logic     i_core_clk,
    input  wire logic     i_arst_n,
    input  wire logic     i_page_sel,
    input  wire ccd_req_t i_req,
    input  wire logic     i_codec_powered_down,
    input  wire logic     i_dout_valid,
    input  wire logic     i_gp_pin_is_wclk,
    output logic          o_hit,
    output logic [7:0]    o_rdata,
    output logic          o_rvalid,
    output ccd_cfg_t      o_cfg,
    output logic          o_agc_fsref_441,
    output logic          o_frac_invalid,
    output logic          o_dual_mismatch,
    output logic          o_clk_gen_run,
    output logic          o_bclk_oe,
    output logic          o_wclk_oe,
    output logic          o_gp_pin_one_oe,
    output logic          o_dout_oe
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (FRAC_MAX < 0 || FRAC_MAX >= (1 << CCD_FRAC_W)) begin : g_bad_frac_max
        $error("FRAC_MAX does not fit the fractional field");
    end

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic [4:0] dec_q(input logic [3:0] code);
        logic [4:0] v;
        v = {1'b0, code};
        if (code == 4'h0) begin
            v = 5'h10;
        end else if (code == 4'h1) begin
            v = 5'h11;
        end
        return v;
    endfunction : dec_q

    function automatic logic [3:0] dec_p(input logic [2:0] code);
        return (code == 3'h0) ? 4'h8 : {1'b0, code};
    endfunction : dec_p

    // right channel swaps the meaning of codes 01 and 10
    function automatic ccd_dac_src_t dec_src(input logic [1:0] code, input logic is_right);
        ccd_dac_src_t s;
        case (code)
            2'h0: s = CCD_SRC_MUTE;
            2'h1: s = is_right ? CCD_SRC_RIGHT : CCD_SRC_LEFT;
            2'h2: s = is_right ? CCD_SRC_LEFT : CCD_SRC_RIGHT;
            default: s = CCD_SRC_MONO;
        endcase
        return s;
    endfunction : dec_src

    // ------------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------------
    logic       page0;
    logic       mapped;
    logic       wr_hit;
    logic [7:0] reg_pll_a;
    logic [7:0] reg_pll_j;
    logic [7:0] reg_frac_hi;
    logic [7:0] reg_frac_lo;
    logic [7:0] reg_dpath;
    logic [7:0] reg_sport;
    logic [CCD_FRAC_W-1:0] frac_applied;
    ccd_cfg_t   next_cfg;
    logic [7:0] next_rdata;

    assign page0  = ~i_page_sel;
    assign mapped = (i_req.addr >= CCD_OFS_PLL_A) && (i_req.addr <= CCD_OFS_SPORT);
    assign o_hit  = page0 && mapped && (i_req.wr || i_req.rd);
    assign wr_hit = page0 && mapped && i_req.wr;

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            reg_pll_a   <= CCD_RST_PLL_A;
            reg_frac_hi <= CCD_RST_FRAC_HI;
            reg_frac_lo <= CCD_RST_FRAC_LO;
            reg_dpath   <= CCD_RST_DPATH;
            reg_sport   <= CCD_RST_SPORT;
        end else if (wr_hit) begin
            case (i_req.addr)
                CCD_OFS_PLL_A:   reg_pll_a <= i_req.wdata;
                CCD_OFS_FRAC_HI: reg_frac_hi <= i_req.wdata;
                CCD_OFS_FRAC_LO: reg_frac_lo <= {i_req.wdata[7:CCD_FRAC_LO_LSB], 2'h0};
                CCD_OFS_DPATH:   reg_dpath <= i_req.wdata;
                CCD_OFS_SPORT:   reg_sport <= i_req.wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            reg_pll_j <= CCD_RST_PLL_J;
        end else if (wr_hit && i_req.addr == CCD_OFS_PLL_J && i_req.wdata[CCD_J_MSB:CCD_J_LSB] != 6'h00) begin
            reg_pll_j <= i_req.wdata;
        end
    end

    // fraction applied as one word when the low byte lands, so a lone high write stays staged
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            frac_applied <= '0;
        end else if (wr_hit && i_req.addr == CCD_OFS_FRAC_LO) begin
            frac_applied <= {reg_frac_hi, i_req.wdata[7:CCD_FRAC_LO_LSB]};
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    always_comb begin
        case (i_req.addr)
            CCD_OFS_PLL_A:   next_rdata = reg_pll_a;
            CCD_OFS_PLL_J:   next_rdata = reg_pll_j;
            CCD_OFS_FRAC_HI: next_rdata = reg_frac_hi;
            CCD_OFS_FRAC_LO: next_rdata = reg_frac_lo;
            CCD_OFS_DPATH:   next_rdata = reg_dpath;
            CCD_OFS_SPORT:   next_rdata = reg_sport;
            default:         next_rdata = CCD_RD_UNMAPPED;
        endcase
        if (!page0) begin
            next_rdata = CCD_RD_UNMAPPED;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata  <= '0;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_req.rd && page0;
            if (i_req.rd && page0) begin
                o_rdata <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // decoded configuration
    // ------------------------------------------------------------------
    always_comb begin
        next_cfg.pll_en        = reg_pll_a[CCD_PLL_EN_BIT];
        next_cfg.pll_q         = dec_q(reg_pll_a[CCD_Q_MSB:CCD_Q_LSB]);
        next_cfg.pll_p         = dec_p(reg_pll_a[CCD_P_MSB:0]);
        next_cfg.pll_j         = reg_pll_j[CCD_J_MSB:CCD_J_LSB];
        next_cfg.pll_d         = frac_applied;
        next_cfg.fsref_441     = reg_dpath[CCD_FSREF_BIT];
        next_cfg.adc_dual      = reg_dpath[CCD_ADC_DR_BIT];
        next_cfg.dac_dual      = reg_dpath[CCD_DAC_DR_BIT];
        next_cfg.left_src      = dec_src(reg_dpath[CCD_LSRC_LSB+1:CCD_LSRC_LSB], 1'b0);
        next_cfg.right_src     = dec_src(reg_dpath[CCD_RSRC_LSB+1:CCD_RSRC_LSB], 1'b1);
        next_cfg.bclk_master   = reg_sport[CCD_BCLK_M_BIT];
        next_cfg.wclk_master   = reg_sport[CCD_WCLK_M_BIT];
        next_cfg.dout_tristate = reg_sport[CCD_DOUT_TS_BIT];
        next_cfg.clk_keep      = reg_sport[CCD_CLK_KEEP_BIT];
        next_cfg.effect3d      = reg_sport[CCD_FX3D_BIT];
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_cfg           <= '0;
            o_agc_fsref_441 <= 1'b0;
            o_frac_invalid  <= 1'b0;
            o_dual_mismatch <= 1'b0;
        end else begin
            o_cfg           <= next_cfg;
            o_agc_fsref_441 <= next_cfg.fsref_441;
            // flags an out-of-range fraction left by the host
            o_frac_invalid  <= frac_applied > FRAC_MAX[CCD_FRAC_W-1:0];
            o_dual_mismatch <= next_cfg.adc_dual ^ next_cfg.dac_dual;
        end
    end

    // ------------------------------------------------------------------
    // serial port pin control
    // ------------------------------------------------------------------
    // clock generation through power-down
    assign o_clk_gen_run   = (o_cfg.bclk_master || o_cfg.wclk_master) &&
                             (!i_codec_powered_down || o_cfg.clk_keep);
    assign o_bclk_oe       = o_cfg.bclk_master && o_clk_gen_run;
    // word clock on its pin or the general-purpose pin
    assign o_wclk_oe       = o_cfg.wclk_master && o_clk_gen_run && !i_gp_pin_is_wclk;
    assign o_gp_pin_one_oe = o_cfg.wclk_master && o_clk_gen_run && i_gp_pin_is_wclk;
    // float data output between valid bits
    assign o_dout_oe       = !o_cfg.dout_tristate || i_dout_valid;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_pll_en;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (wr_hit && i_req.addr == CCD_OFS_PLL_A) |-> ##2 (o_cfg.pll_en == $past(i_req.wdata[7], 2));
    endproperty
    a_pll_en: assert property (p_pll_en) else $error("multiplier enable does not follow d7");

    property p_q_range;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (o_cfg.pll_q >= 5'h02 && o_cfg.pll_q <= 5'h11) ||
        (o_cfg.pll_q == 5'h00 && $past(o_cfg.pll_q) == 5'h00);
    endproperty
    a_q_range: assert property (p_q_range) else $error("output divider outside 2..17");

    property p_q_decode;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (wr_hit && i_req.addr == CCD_OFS_PLL_A && i_req.wdata[6:3] == 4'h1) |-> ##2 (o_cfg.pll_q == 5'h11);
    endproperty
    a_q_decode: assert property (p_q_decode) else $error("code 0001 not decoded as 17");

    property p_p_decode;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (wr_hit && i_req.addr == CCD_OFS_PLL_A && i_req.wdata[2:0] == 3'h0) |-> ##2 (o_cfg.pll_p == 4'h8);
    endproperty
    a_p_decode: assert property (p_p_decode) else $error("code 000 not decoded as 8");

    property p_j_nonzero;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (wr_hit && i_req.addr == CCD_OFS_PLL_J && i_req.wdata[7:2] == 6'h00) |=> $stable(reg_pll_j);
    endproperty
    a_j_nonzero: assert property (p_j_nonzero) else $error("reserved zero multiplier accepted");

    property p_frac_pair;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (wr_hit && i_req.addr == CCD_OFS_FRAC_LO) |-> ##2
            (o_cfg.pll_d == {$past(reg_frac_hi, 2), $past(i_req.wdata[7:2], 2)});
    endproperty
    a_frac_pair: assert property (p_frac_pair) else $error("fraction not formed from both bytes");

    property p_frac_lo_rd;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (i_req.rd && page0 && i_req.addr == CCD_OFS_FRAC_LO) |=> (o_rvalid && o_rdata[1:0] == 2'h0);
    endproperty
    a_frac_lo_rd: assert property (p_frac_lo_rd) else $error("read-only fraction bits not zero");

    property p_src_right;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (wr_hit && i_req.addr == CCD_OFS_DPATH && i_req.wdata[2:1] == 2'h1) |-> ##2
            (o_cfg.right_src == CCD_SRC_RIGHT);
    endproperty
    a_src_right: assert property (p_src_right) else $error("right source code 01 misrouted");

    property p_dout_float;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (o_cfg.dout_tristate && !i_dout_valid) |-> !o_dout_oe;
    endproperty
    a_dout_float: assert property (p_dout_float) else $error("data output driven between valid bits");

    property p_clk_stop;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (i_codec_powered_down && !o_cfg.clk_keep) |-> !(o_bclk_oe || o_wclk_oe || o_gp_pin_one_oe);
    endproperty
    a_clk_stop: assert property (p_clk_stop) else $error("master clocks run through power-down");

    property p_page1;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        i_page_sel |=> ($stable(reg_dpath) && $stable(reg_sport) && $stable(reg_pll_a));
    endproperty
    a_page1: assert property (p_page1) else $error("page-one access changed a register");

    property p_fsref_agc;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (wr_hit && i_req.addr == CCD_OFS_DPATH) |-> ##2 (o_agc_fsref_441 == $past(i_req.wdata[7], 2));
    endproperty
    a_fsref_agc: assert property (p_fsref_agc) else $error("gain-loop rate select does not follow d7");

    property p_dual_rate;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (wr_hit && i_req.addr == CCD_OFS_DPATH) |-> ##2
            (o_cfg.adc_dual == $past(i_req.wdata[6], 2) && o_cfg.dac_dual == $past(i_req.wdata[5], 2));
    endproperty
    a_dual_rate: assert property (p_dual_rate) else $error("dual-rate modes do not follow d6 and d5");

    property p_src_left;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (wr_hit && i_req.addr == CCD_OFS_DPATH && i_req.wdata[4:3] == 2'h2) |-> ##2
            (o_cfg.left_src == CCD_SRC_RIGHT);
    endproperty
    a_src_left: assert property (p_src_left) else $error("left source code 10 misrouted");

    property p_bclk_slave;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        !o_cfg.bclk_master |-> !o_bclk_oe;
    endproperty
    a_bclk_slave: assert property (p_bclk_slave) else $error("bit clock driven in slave mode");

    property p_fx3d;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (wr_hit && i_req.addr == CCD_OFS_SPORT) |-> ##2 (o_cfg.effect3d == $past(i_req.wdata[2], 2));
    endproperty
    a_fx3d: assert property (p_fx3d) else $error("3-d effect enable does not follow d2");

    c_frac_write: cover property (@(posedge i_core_clk) disable iff (!i_arst_n)
        (wr_hit && i_req.addr == CCD_OFS_FRAC_HI) ##2 (wr_hit && i_req.addr == CCD_OFS_FRAC_LO));
    c_master_keep: cover property (@(posedge i_core_clk) disable iff (!i_arst_n)
        i_codec_powered_down && o_bclk_oe);
    c_mono_mix: cover property (@(posedge i_core_clk) disable iff (!i_arst_n)
        o_cfg.left_src == CCD_SRC_MONO && o_cfg.right_src == CCD_SRC_MONO);
    c_pll_on: cover property (@(posedge i_core_clk) disable iff (!i_arst_n) $rose(o_cfg.pll_en));

endmodule : ccd_regs

// File: ccd_host_model.sv
// Purpose: host model issuing decoded register requests and the page select
// Assumes: a request starts 1 ns after a rising edge and is taken at the next one
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/1ns

module ccd_host_model
    import ccd_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rvalid,
    input  wire logic [7:0] i_rdata,
    output ccd_req_t        o_req,
    output logic            o_page_sel
);
    initial begin
        o_req      = '0;
        o_page_sel = 1'b0;
    end

    task automatic set_page(input logic pg);
        @(posedge i_core_clk);
        #1 o_page_sel = pg;
    endtask : set_page

    // raw skips the host's own care, only where a scenario asks for a bad write
    task automatic access(input logic rd, input logic [6:0] a, input logic [7:0] d,
                          input logic raw, output logic ok, output logic [7:0] q);
        logic [7:0] v;
        v = d;
        if (!raw) begin
            if (a == CCD_OFS_PLL_J || a == CCD_OFS_FRAC_LO || a == CCD_OFS_SPORT)
                v[1:0] = 2'h0;
            if (a == CCD_OFS_SPORT)
                v[3] = 1'b0;
            if (a == CCD_OFS_DPATH) begin
                v[0] = 1'b0;
                v[6] = v[5];
            end
            if (a == CCD_OFS_PLL_J && v[7:2] == 6'h00)
                v[7:2] = 6'h01;
        end
        @(posedge i_core_clk);
        #1 o_req = '{wr: !rd, rd: rd, addr: a, wdata: v};
        @(posedge i_core_clk);
        #1;
        ok = i_rvalid;
        q = i_rdata;
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
    endtask : access

    // clamp, then high and low part in turn
    task automatic set_frac(input int unsigned f);
        logic [13:0] x;
        logic        ok;
        logic [7:0]  q;
        x = (f > CCD_FRAC_MAX) ? 14'(CCD_FRAC_MAX) : 14'(f);
        access(1'b0, CCD_OFS_FRAC_HI, x[13:6], 1'b0, ok, q);
        access(1'b0, CCD_OFS_FRAC_LO, {x[5:0], 2'h0}, 1'b0, ok, q);
    endtask : set_frac
endmodule : ccd_host_model

// File: ccd_regs_bench.sv
// Purpose: self-checking bench of the clock/datapath register bank
// Assumes: 125 MHz core clock, inputs change 1 ns after the rising edge
// Notes:   pin checks wait 1 ns after an input change for the logic to settle
`timescale 1ns/1ns

module ccd_regs_bench;
    import ccd_pkg::*;
    logic       i_core_clk, i_arst_n, pwr_dn, dout_valid, gp_wclk, page_sel, hit, rvalid;
    logic       agc441, frac_inv, dual_mis, clk_run, bclk_oe, wclk_oe, gp_oe, dout_oe, ok;
    logic [7:0] rdata, q;
    logic       hit_q;
    ccd_req_t   req;
    ccd_cfg_t   cfg;
    int         mismatches = 0, n_tests = 0, cyc = 0;

    ccd_host_model u_host (.i_core_clk(i_core_clk), .i_rvalid(rvalid), .i_rdata(rdata),
                           .o_req(req), .o_page_sel(page_sel));
    ccd_regs #(.FRAC_MAX(CCD_FRAC_MAX)) u_dut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
        .i_page_sel(page_sel), .i_req(req), .i_codec_powered_down(pwr_dn),
        .i_dout_valid(dout_valid), .i_gp_pin_is_wclk(gp_wclk), .o_hit(hit), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_cfg(cfg), .o_agc_fsref_441(agc441), .o_frac_invalid(frac_inv),
        .o_dual_mismatch(dual_mis), .o_clk_gen_run(clk_run), .o_bclk_oe(bclk_oe),
        .o_wclk_oe(wclk_oe), .o_gp_pin_one_oe(gp_oe), .o_dout_oe(dout_oe));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // hit lasts only while a request stands, so keep what the taking edge saw
    always @(posedge i_core_clk) hit_q <= hit;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_host.access(1'b0, a, d, 1'b0, ok, q);
        @(posedge i_core_clk);
        #1;
    endtask : wr

    task automatic pins(input logic pd, input logic dv, input logic gp);
        @(posedge i_core_clk);
        #1 {pwr_dn, dout_valid, gp_wclk} = {pd, dv, gp};
        #1;
    endtask : pins

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] ev [6] = '{8'h10, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            u_host.access(1'b1, 7'(3 + i), 8'h00, 1'b0, ok, q);
            chk("rst_ok", ok, 1);
            chk("rst_hit", hit_q, 1);
            chk("rst_val", q, ev[i]);
        end
        chk("rst_en", cfg.pll_en, 0);
        chk("rst_q", cfg.pll_q, 2);
        chk("rst_p", cfg.pll_p, 8);
        chk("rst_j", cfg.pll_j, 1);
    endtask : t_reset

    task automatic t_pll;
        logic [3:0] qc [4] = '{4'h0, 4'h1, 4'h2, 4'hf};
        int         qv [4] = '{16, 17, 2, 15};
        logic [2:0] pc [4] = '{3'h0, 3'h1, 3'h7, 3'h3};
        int         pv [4] = '{8, 1, 7, 3};
        for (int i = 0; i < 4; i++) begin
            wr(CCD_OFS_PLL_A, {i[0], qc[i], pc[i]});
            chk("pll_en", cfg.pll_en, i[0]);
            chk("pll_q", cfg.pll_q, qv[i]);
            chk("pll_p", cfg.pll_p, pv[i]);
        end
    endtask : t_pll

    task automatic t_mult;
        wr(CCD_OFS_PLL_J, 8'hfc);
        chk("j_max", cfg.pll_j, 63);
        // a zero multiplier is forced through on purpose and must be ignored
        u_host.access(1'b0, CCD_OFS_PLL_J, 8'h00, 1'b1, ok, q);
        u_host.access(1'b1, CCD_OFS_PLL_J, 8'h00, 1'b0, ok, q);
        chk("j_keep", q, 8'hfc);
        chk("j_cfg", cfg.pll_j, 63);
        wr(CCD_OFS_FRAC_HI, 8'h9c);
        chk("d_hold", cfg.pll_d, 0);
        wr(CCD_OFS_FRAC_LO, 8'h3c);
        chk("d_max", cfg.pll_d, 9999);
        chk("d_ok", frac_inv, 0);
        // a fraction of 10000 is forced through on purpose to trip the flag
        u_host.access(1'b0, CCD_OFS_FRAC_LO, 8'h40, 1'b1, ok, q);
        @(posedge i_core_clk);
        #1 chk("d_big", frac_inv, 1);
        u_host.set_frac(37);
        @(posedge i_core_clk);
        #1 chk("d_small", cfg.pll_d, 37);
        u_host.access(1'b0, CCD_OFS_FRAC_LO, 8'h97, 1'b1, ok, q);
        u_host.access(1'b1, CCD_OFS_FRAC_LO, 8'h00, 1'b0, ok, q);
        chk("lo_ro", q, 8'h94);
    endtask : t_mult

    task automatic t_dpath;
        ccd_dac_src_t ls [4] = '{CCD_SRC_MUTE, CCD_SRC_LEFT, CCD_SRC_RIGHT, CCD_SRC_MONO};
        ccd_dac_src_t rs [4] = '{CCD_SRC_MONO, CCD_SRC_LEFT, CCD_SRC_RIGHT, CCD_SRC_MUTE};
        // mismatched dual rates are forced through on purpose to trip the flag
        u_host.access(1'b0, CCD_OFS_DPATH, 8'h40, 1'b1, ok, q);
        @(posedge i_core_clk);
        #1 chk("dual_bad", dual_mis, 1);
        for (int i = 0; i < 4; i++) begin
            wr(CCD_OFS_DPATH, {i[0], i[1], i[1], 2'(i), 2'(3 - i), 1'b0});
            chk("fsref", cfg.fsref_441, i[0]);
            chk("agc", agc441, i[0]);
            chk("adc_dr", cfg.adc_dual, i[1]);
            chk("dac_dr", cfg.dac_dual, i[1]);
            chk("dual_ok", dual_mis, 0);
            chk("lsrc", cfg.left_src, ls[i]);
            chk("rsrc", cfg.right_src, rs[i]);
        end
    endtask : t_dpath

    task automatic t_sport;
        wr(CCD_OFS_SPORT, 8'he4);
        pins(1'b0, 1'b1, 1'b0);
        chk("bclk_m", bclk_oe, 1);
        chk("wclk_m", {wclk_oe, gp_oe}, 2'h2);
        chk("fx_on", cfg.effect3d, 1);
        chk("dout_v", dout_oe, 1);
        pins(1'b0, 1'b0, 1'b1);
        chk("dout_ts", dout_oe, 0);
        chk("gp_m", {wclk_oe, gp_oe}, 2'h1);
        pins(1'b1, 1'b0, 1'b0);
        chk("pd_stop", {clk_run, bclk_oe, wclk_oe}, 3'h0);
        wr(CCD_OFS_SPORT, 8'hd0);
        chk("pd_keep", {bclk_oe, wclk_oe}, 2'h3);
        chk("dout_drv", dout_oe, 1);
        chk("fx_off", cfg.effect3d, 0);
        wr(CCD_OFS_SPORT, 8'h00);
        chk("slave", {bclk_oe, wclk_oe, gp_oe}, 3'h0);
    endtask : t_sport

    task automatic t_page;
        u_host.set_page(1'b1);
        wr(CCD_OFS_DPATH, 8'h08);
        chk("pg1_wr", cfg.left_src, CCD_SRC_MONO);
        u_host.access(1'b1, CCD_OFS_DPATH, 8'h00, 1'b0, ok, q);
        chk("pg1_rd", ok, 0);
        chk("pg1_hit", hit_q, 0);
        u_host.set_page(1'b0);
        u_host.access(1'b1, CCD_OFS_DPATH, 8'h00, 1'b0, ok, q);
        chk("pg0_rd", {ok, q}, 9'h1f8);
        chk("pg0_hit", hit_q, 1);
        u_host.access(1'b1, 7'h40, 8'h00, 1'b0, ok, q);
        chk("unmapped", {ok, q}, 9'h100);
        chk("unm_hit", hit_q, 0);
    endtask : t_page

    // ------------------------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------------------------
    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end

    // the whole run needs about a hundred cycles
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            test_done();
        end
    end

    initial begin
        {i_arst_n, pwr_dn, dout_valid, gp_wclk} = 4'h0;
        repeat (12) @(posedge i_core_clk);
        #1 i_arst_n = 1'b1;
        t_reset();
        t_pll();
        t_mult();
        t_dpath();
        t_sport();
        t_page();
        test_done();
    end
endmodule : ccd_regs_bench
